// ===== hdl/hcer_defines.vh
// Offsets, field positions and reset values of the host configuration and error registers
`ifndef HCER_DEFINES_VH
`define HCER_DEFINES_VH
// ************************************************
// Register byte offsets
// ************************************************
`define HCER_OFS_CFG_ADDR 8'h00
`define HCER_OFS_CFG_DATA 8'h04
`define HCER_OFS_BUS_NUM 8'h08
`define HCER_OFS_INHIBIT 8'h0C
`define HCER_OFS_ERR_DEF 8'h10
`define HCER_OFS_RD_EADDR 8'h14
`define HCER_OFS_WR_EADDR 8'h18
// ************************************************
// Writable bit masks
// ************************************************
`define HCER_CFG_ADDR_MASK 32'h01FF_FF3F
`define HCER_BUS_NUM_MASK 32'hFF00_FF00
`define HCER_INHIBIT_MASK 32'hC000_0000
// ************************************************
// Field positions
// ************************************************
`define HCER_CA_REG_LSB 0
`define HCER_CA_REG_MSB 5
`define HCER_CA_DEV_LSB 8
`define HCER_CA_DEV_MSB 12
`define HCER_CA_FUNC_LSB 13
`define HCER_CA_FUNC_MSB 15
`define HCER_CA_BUS_LSB 16
`define HCER_CA_BUS_MSB 23
`define HCER_CA_ENABLE_BIT 24
`define HCER_BN_PRIM_LSB 8
`define HCER_BN_PRIM_MSB 15
`define HCER_BN_SUB_LSB 24
`define HCER_BN_SUB_MSB 31
`define HCER_INH_WR_BIT 30
`define HCER_INH_RD_BIT 31
`define HCER_ERR_LSB 21
`define HCER_ERR_WR_MSB 28
`define HCER_ERR_RD_LSB 29
`define HCER_ERR_MSB 31
// ************************************************
// Reset values and responses
// ************************************************
`define HCER_RST_WORD 32'h0000_0000
`define HCER_RESP_OKAY 2'h0
`define HCER_RESP_SLVERR 2'h2
`define HCER_RESP_DECERR 2'h3
`endif

// ===== hdl/hcer_regs.v
// Host configuration port and master error registers behind an AXI4-Lite slave
//
// Notes on behaviour
// - Address port bit 24 enables configuration cycles
// - Address port bits 25-31 read zero
// - Configuration registers exist only with both options
// - Data port read/write launches configuration read/write
// - Command target taken from address port
// - Type chosen by comparing against bus numbers
// - Configuration data byte-swapped toward the link
// - Reset clears data port and bus numbers
// - Primary bits 8-15, subordinate 24-31, rest zero
// - Error registers exist only with error and path options and nonzero FIFO widths
// - Write inhibit plus write error retries writes
// - Read inhibit plus read error retries reads
// - Independent gating, inhibit low bits read zero
// - Error bits cleared by writing one
// - Bit 21 on overrun, write address captured
// - Bits 22-24 retry timeout, disconnect, retry
// - Bits 25-28 write abort, parity, system errors
// - Bits 29-31 read errors, bits 0-20 zero
// - Read error address captured, overwrites unless inhibited
// - Write error address captured, overwrites unless inhibited
// - Bus 16-23, device 8-12, function 13-15
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "hcer_defines.vh"

module hcer_regs #(
    parameter HOST_CFG_INCLUDED = 1,
    parameter MASTER_TO_TARGET_PATH_INCLUDED = 1,
    parameter ERR_MODULE_INCLUDED = 1,
    parameter INBOUND_FIFO_ADDR_WIDTH = 9,
    parameter OUTBOUND_FIFO_ADDR_WIDTH = 9
) (
    input wire i_clk,
    input wire i_rst,
    input wire [7:0] i_awaddr,
    input wire i_awvalid,
    output reg o_awready,
    input wire [31:0] i_wdata,
    input wire [3:0] i_wstrb,
    input wire i_wvalid,
    output reg o_wready,
    output reg [1:0] o_bresp,
    output reg o_bvalid,
    input wire i_bready,
    input wire [7:0] i_araddr,
    input wire i_arvalid,
    output reg o_arready,
    output reg [31:0] o_rdata,
    output reg [1:0] o_rresp,
    output reg o_rvalid,
    input wire i_rready,
    output reg o_cfg_req,
    output reg o_cfg_write,
    output reg o_cfg_type1,
    output reg [7:0] o_cfg_bus,
    output reg [4:0] o_cfg_dev,
    output reg [2:0] o_cfg_func,
    output reg [5:0] o_cfg_word,
    output reg [31:0] o_cfg_wdata,
    input wire i_cfg_done,
    input wire [31:0] i_cfg_rdata,
    input wire [7:0] i_wr_err,
    input wire [31:0] i_wr_err_addr,
    input wire [2:0] i_rd_err,
    input wire [31:0] i_rd_err_addr,
    output reg o_wr_retry,
    output reg o_rd_retry
);

    // ************************************************
    // Build options
    // ************************************************
    localparam HAS_CFG = (HOST_CFG_INCLUDED != 0) && (MASTER_TO_TARGET_PATH_INCLUDED != 0);
    localparam HAS_ERR = (ERR_MODULE_INCLUDED != 0) && (MASTER_TO_TARGET_PATH_INCLUDED != 0)
        && (INBOUND_FIFO_ADDR_WIDTH != 0) && (OUTBOUND_FIFO_ADDR_WIDTH != 0);

    localparam [4:0] S_IDLE = 5'b00001;
    localparam [4:0] S_WCFG = 5'b00010;
    localparam [4:0] S_RCFG = 5'b00100;
    localparam [4:0] S_BRSP = 5'b01000;
    localparam [4:0] S_RRSP = 5'b10000;

    function [31:0] swap32;
        input [31:0] v;
        begin
            swap32 = {v[7:0], v[15:8], v[23:16], v[31:24]};
        end
    endfunction

    function [31:0] strb_mask;
        input [3:0] s;
        begin
            strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        end
    endfunction

    reg [4:0] state_q, state_d;
    reg aw_have_q, aw_have_d;
    reg w_have_q, w_have_d;
    reg ar_have_q, ar_have_d;
    reg [7:0] awaddr_q, araddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg [31:0] cfg_addr_q, cfg_addr_d;
    reg [31:0] cfg_data_q, cfg_data_d;
    reg [31:0] bus_num_q, bus_num_d;
    reg [31:0] inhibit_q, inhibit_d;
    reg [10:0] err_q, err_d;
    reg [31:0] rd_eaddr_q, rd_eaddr_d;
    reg [31:0] wr_eaddr_q, wr_eaddr_d;
    reg cfg_req_d, cfg_write_d, cfg_type1_d;
    reg [31:0] cfg_wdata_d;
    reg bvalid_d, rvalid_d;
    reg [1:0] bresp_d, rresp_d;
    reg [31:0] rdata_d;
    reg [10:0] err_clr;
    reg [31:0] wmask;

    wire aw_take = i_awvalid && o_awready;
    wire w_take = i_wvalid && o_wready;
    wire ar_take = i_arvalid && o_arready;

    // ************************************************
    // Command target and type
    // ************************************************
    wire [7:0] tgt_bus = cfg_addr_q[`HCER_CA_BUS_MSB:`HCER_CA_BUS_LSB];
    wire [7:0] prim_bus = bus_num_q[`HCER_BN_PRIM_MSB:`HCER_BN_PRIM_LSB];
    wire [7:0] sub_bus = bus_num_q[`HCER_BN_SUB_MSB:`HCER_BN_SUB_LSB];
    wire is_type0 = (tgt_bus == prim_bus);
    wire is_type1 = (tgt_bus > prim_bus) && (tgt_bus <= sub_bus);
    wire cfg_on = cfg_addr_q[`HCER_CA_ENABLE_BIT];

    wire wr_recorded = |err_q[`HCER_ERR_WR_MSB-`HCER_ERR_LSB:0];
    wire rd_recorded = |err_q[`HCER_ERR_MSB-`HCER_ERR_LSB:`HCER_ERR_RD_LSB-`HCER_ERR_LSB];
    wire inh_wr = inhibit_q[`HCER_INH_WR_BIT];
    wire inh_rd = inhibit_q[`HCER_INH_RD_BIT];

    // ************************************************
    // Register read multiplexer
    // ************************************************
    reg [31:0] rd_word;
    reg rd_hit;
    always @* begin
        rd_word = `HCER_RST_WORD;
        rd_hit = 1'b1;
        case (araddr_q)
            `HCER_OFS_CFG_ADDR: rd_word = cfg_addr_q;
            `HCER_OFS_CFG_DATA: rd_word = cfg_data_q;
            `HCER_OFS_BUS_NUM: rd_word = bus_num_q;
            `HCER_OFS_INHIBIT: rd_word = inhibit_q;
            `HCER_OFS_ERR_DEF: rd_word = {err_q, 21'h00_0000};
            `HCER_OFS_RD_EADDR: rd_word = rd_eaddr_q;
            `HCER_OFS_WR_EADDR: rd_word = wr_eaddr_q;
            default: rd_hit = 1'b0;
        endcase
        if (!HAS_CFG && (araddr_q <= `HCER_OFS_BUS_NUM)) begin
            rd_hit = 1'b0;
        end
        if (!HAS_ERR && (araddr_q >= `HCER_OFS_INHIBIT)) begin
            rd_hit = 1'b0;
        end
    end

    wire wr_cfg_map = (awaddr_q <= `HCER_OFS_BUS_NUM) && (awaddr_q[1:0] == 2'h0);
    wire wr_err_map = (awaddr_q >= `HCER_OFS_INHIBIT) && (awaddr_q <= `HCER_OFS_WR_EADDR)
        && (awaddr_q[1:0] == 2'h0);
    wire wr_hit = (HAS_CFG && wr_cfg_map) || (HAS_ERR && wr_err_map);

    // ************************************************
    // Next-state logic
    // ************************************************
    always @* begin
        state_d = state_q;
        aw_have_d = aw_have_q | aw_take;
        w_have_d = w_have_q | w_take;
        ar_have_d = ar_have_q | ar_take;
        cfg_addr_d = cfg_addr_q;
        cfg_data_d = cfg_data_q;
        bus_num_d = bus_num_q;
        inhibit_d = inhibit_q;
        rd_eaddr_d = rd_eaddr_q;
        wr_eaddr_d = wr_eaddr_q;
        cfg_req_d = o_cfg_req;
        cfg_write_d = o_cfg_write;
        cfg_type1_d = o_cfg_type1;
        cfg_wdata_d = o_cfg_wdata;
        bvalid_d = o_bvalid && !i_bready;
        rvalid_d = o_rvalid && !i_rready;
        bresp_d = o_bresp;
        rresp_d = o_rresp;
        rdata_d = o_rdata;
        err_clr = 11'h000;
        wmask = strb_mask(wstrb_q);
        case (state_q)
            S_IDLE: begin
                if (aw_have_q && w_have_q) begin
                    aw_have_d = 1'b0;
                    w_have_d = 1'b0;
                    bresp_d = wr_hit ? `HCER_RESP_OKAY : `HCER_RESP_DECERR;
                    state_d = S_BRSP;
                    if (wr_hit) begin
                        case (awaddr_q)
                            `HCER_OFS_CFG_ADDR: begin
                                cfg_addr_d = (cfg_addr_q & ~(wmask & `HCER_CFG_ADDR_MASK))
                                    | (wdata_q & wmask & `HCER_CFG_ADDR_MASK);
                            end
                            `HCER_OFS_CFG_DATA: begin
                                if (wstrb_q != 4'hF) begin
                                    bresp_d = `HCER_RESP_SLVERR;
                                end else begin
                                    cfg_data_d = wdata_q;
                                    if (cfg_on && (is_type0 || is_type1)) begin
                                        cfg_req_d = 1'b1;
                                        cfg_write_d = 1'b1;
                                        cfg_type1_d = !is_type0;
                                        cfg_wdata_d = swap32(wdata_q);
                                        state_d = S_WCFG;
                                    end else if (cfg_on) begin
                                        bresp_d = `HCER_RESP_SLVERR;
                                    end
                                end
                            end
                            `HCER_OFS_BUS_NUM: begin
                                bus_num_d = (bus_num_q & ~(wmask & `HCER_BUS_NUM_MASK))
                                    | (wdata_q & wmask & `HCER_BUS_NUM_MASK);
                            end
                            `HCER_OFS_INHIBIT: begin
                                inhibit_d = (inhibit_q & ~(wmask & `HCER_INHIBIT_MASK))
                                    | (wdata_q & wmask & `HCER_INHIBIT_MASK);
                            end
                            `HCER_OFS_ERR_DEF: begin
                                err_clr = wdata_q[31:21] & wmask[31:21];
                            end
                            default: begin
                                bresp_d = `HCER_RESP_OKAY;
                            end
                        endcase
                    end
                end else if (ar_have_q) begin
                    ar_have_d = 1'b0;
                    rdata_d = rd_hit ? rd_word : `HCER_RST_WORD;
                    rresp_d = rd_hit ? `HCER_RESP_OKAY : `HCER_RESP_DECERR;
                    state_d = S_RRSP;
                    if (rd_hit && (araddr_q == `HCER_OFS_CFG_DATA) && cfg_on) begin
                        if (is_type0 || is_type1) begin
                            cfg_req_d = 1'b1;
                            cfg_write_d = 1'b0;
                            cfg_type1_d = !is_type0;
                            state_d = S_RCFG;
                        end else begin
                            rresp_d = `HCER_RESP_SLVERR;
                        end
                    end
                end
            end
            S_WCFG: begin
                if (i_cfg_done) begin
                    cfg_req_d = 1'b0;
                    state_d = S_BRSP;
                end
            end
            S_RCFG: begin
                if (i_cfg_done) begin
                    cfg_req_d = 1'b0;
                    cfg_data_d = swap32(i_cfg_rdata);
                    rdata_d = swap32(i_cfg_rdata);
                    state_d = S_RRSP;
                end
            end
            S_BRSP: begin
                if (!o_bvalid) begin
                    bvalid_d = 1'b1;
                end else if (i_bready) begin
                    state_d = S_IDLE;
                end
            end
            S_RRSP: begin
                if (!o_rvalid) begin
                    rvalid_d = 1'b1;
                end else if (i_rready) begin
                    state_d = S_IDLE;
                end
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
        // Set wins over a simultaneous software clear
        err_d = (err_q & ~err_clr) | {i_rd_err, i_wr_err};
        if ((|i_wr_err) && !(inh_wr && wr_recorded)) begin
            wr_eaddr_d = i_wr_err_addr;
        end
        if ((|i_rd_err) && !(inh_rd && rd_recorded)) begin
            rd_eaddr_d = i_rd_err_addr;
        end
        if (!HAS_CFG) begin
            cfg_addr_d = `HCER_RST_WORD;
            cfg_data_d = `HCER_RST_WORD;
            bus_num_d = `HCER_RST_WORD;
            cfg_req_d = 1'b0;
        end
        if (!HAS_ERR) begin
            inhibit_d = `HCER_RST_WORD;
            err_d = 11'h000;
            rd_eaddr_d = `HCER_RST_WORD;
            wr_eaddr_d = `HCER_RST_WORD;
        end
    end

    // ************************************************
    // Registers
    // ************************************************
    always @(posedge i_clk) begin
        if (i_rst) begin
            state_q <= S_IDLE;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            ar_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            araddr_q <= 8'h00;
            wdata_q <= `HCER_RST_WORD;
            wstrb_q <= 4'h0;
            o_awready <= 1'b0;
            o_wready <= 1'b0;
            o_arready <= 1'b0;
            cfg_addr_q <= `HCER_RST_WORD;
            cfg_data_q <= `HCER_RST_WORD;
            bus_num_q <= `HCER_RST_WORD;
            inhibit_q <= `HCER_RST_WORD;
            err_q <= 11'h000;
            rd_eaddr_q <= `HCER_RST_WORD;
            wr_eaddr_q <= `HCER_RST_WORD;
            o_cfg_req <= 1'b0;
            o_cfg_write <= 1'b0;
            o_cfg_type1 <= 1'b0;
            o_cfg_bus <= 8'h00;
            o_cfg_dev <= 5'h00;
            o_cfg_func <= 3'h0;
            o_cfg_word <= 6'h00;
            o_cfg_wdata <= `HCER_RST_WORD;
            o_bvalid <= 1'b0;
            o_bresp <= `HCER_RESP_OKAY;
            o_rvalid <= 1'b0;
            o_rresp <= `HCER_RESP_OKAY;
            o_rdata <= `HCER_RST_WORD;
            o_wr_retry <= 1'b0;
            o_rd_retry <= 1'b0;
        end else begin
            state_q <= state_d;
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            ar_have_q <= ar_have_d;
            if (aw_take) begin
                awaddr_q <= i_awaddr;
            end
            if (w_take) begin
                wdata_q <= i_wdata;
                wstrb_q <= i_wstrb;
            end
            if (ar_take) begin
                araddr_q <= i_araddr;
            end
            o_awready <= !aw_have_d;
            o_wready <= !w_have_d;
            o_arready <= !ar_have_d;
            cfg_addr_q <= cfg_addr_d;
            cfg_data_q <= cfg_data_d;
            bus_num_q <= bus_num_d;
            inhibit_q <= inhibit_d;
            err_q <= err_d;
            rd_eaddr_q <= rd_eaddr_d;
            wr_eaddr_q <= wr_eaddr_d;
            o_cfg_req <= cfg_req_d;
            o_cfg_write <= cfg_write_d;
            o_cfg_type1 <= cfg_type1_d;
            o_cfg_wdata <= cfg_wdata_d;
            if (cfg_req_d && !o_cfg_req) begin
                o_cfg_bus <= tgt_bus;
                o_cfg_dev <= cfg_addr_q[`HCER_CA_DEV_MSB:`HCER_CA_DEV_LSB];
                o_cfg_func <= cfg_addr_q[`HCER_CA_FUNC_MSB:`HCER_CA_FUNC_LSB];
                o_cfg_word <= cfg_addr_q[`HCER_CA_REG_MSB:`HCER_CA_REG_LSB];
            end
            o_bvalid <= bvalid_d;
            o_bresp <= bresp_d;
            o_rvalid <= rvalid_d;
            o_rresp <= rresp_d;
            o_rdata <= rdata_d;
            o_wr_retry <= inh_wr && wr_recorded;
            o_rd_retry <= inh_rd && rd_recorded;
        end
    end

endmodule // hcer_regs

// ===== dv/hcer_regs_checker.sv
// Port-level assertions for the host configuration and error register block
`timescale 1ns/1ps
`include "hcer_defines.vh"

module hcer_regs_checker (
    input wire i_clk,
    input wire i_rst,
    input wire [7:0] i_araddr,
    input wire i_arvalid,
    input wire o_arready,
    input wire o_awready,
    input wire [31:0] o_rdata,
    input wire o_rvalid,
    input wire i_rready,
    input wire [1:0] o_bresp,
    input wire o_bvalid,
    input wire i_bready,
    input wire o_cfg_req,
    input wire o_cfg_write,
    input wire [7:0] o_cfg_bus,
    input wire [5:0] o_cfg_word,
    input wire i_cfg_done,
    input wire o_wr_retry,
    input wire o_rd_retry
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    rst_clear_a: assert property ($fell(i_rst) |-> !(o_cfg_req | o_bvalid | o_rvalid | o_wr_retry | o_rd_retry | o_awready | o_arready))
        else $error("outputs set after reset");
    req_hold_a: assert property (o_cfg_req && !i_cfg_done |=> o_cfg_req && $stable({o_cfg_write, o_cfg_bus, o_cfg_word}))
        else $error("command dropped or target changed");
    req_drop_a: assert property (o_cfg_req && i_cfg_done |=> !o_cfg_req)
        else $error("command not ended after done");
    wr_answer_a: assert property (o_cfg_req && i_cfg_done && o_cfg_write |=> ##1 o_bvalid)
        else $error("no write response after command");
    rd_answer_a: assert property (o_cfg_req && i_cfg_done && !o_cfg_write |=> ##1 o_rvalid)
        else $error("no read response after command");
    launch_busy_a: assert property (o_cfg_req |-> !o_bvalid && !o_rvalid)
        else $error("response during command");
    bresp_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response not held");
    rdata_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data not held");
    plain_read_a: assert property (i_arvalid && o_arready && i_araddr != `HCER_OFS_CFG_DATA |-> ##3 o_rvalid)
        else $error("register read late");
endmodule // hcer_regs_checker

// ===== dv/hcer_link_model.sv
// Link-side model that answers configuration commands after a set delay
`timescale 1ns/1ps

module hcer_link_model (
    input wire i_clk,
    input wire i_rst,
    input wire i_cfg_req,
    input wire [7:0] i_cfg_bus,
    input wire [4:0] i_cfg_dev,
    input wire [2:0] i_cfg_func,
    input wire [5:0] i_cfg_word,
    input wire [3:0] i_delay,
    output reg o_cfg_done,
    output reg [31:0] o_cfg_rdata
);
    reg [3:0] cnt_q = 4'h0;
    initial o_cfg_done = 1'b0;
    initial o_cfg_rdata = 32'h0000_0000;
    always @(posedge i_clk) begin
        o_cfg_done <= 1'b0;
        // Read data inverts every cycle and carries the answer only with done
        o_cfg_rdata <= ~o_cfg_rdata;
        if (i_rst) begin
            cnt_q <= 4'h0;
        end else if (i_cfg_req && !o_cfg_done) begin
            if (cnt_q == i_delay) begin
                o_cfg_done <= 1'b1;
                o_cfg_rdata <= {i_cfg_bus, i_cfg_func, i_cfg_dev, 2'b10, i_cfg_word, 8'h5a};
                cnt_q <= 4'h0;
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end
endmodule // hcer_link_model

// ===== dv/hcer_regs_tb.sv
// Bench for the host configuration and error registers with a link model
`timescale 1ns/1ps
`include "hcer_defines.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; $display("wrong value at %0t: %h not %h", $time, g, e); end end

module hcer_regs_tb;
    reg i_clk, i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, wr, ok, req_q;
    reg [7:0] i_awaddr, i_araddr, i_wr_err, prim, sub, tbus, ea;
    reg [31:0] i_wdata, i_wr_err_addr, i_rd_err_addr, d, a, rd_d, rnd, cap_wd;
    reg [3:0] i_wstrb, delay;
    reg [2:0] i_rd_err;
    reg [1:0] sel, rr;
    reg [23:0] cap;
    integer seed = 32'h8d74, fails = 0, comparisons = 0, launches = 0, i, g, k, n0, lsb, stall;
    wire o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_cfg_req, o_cfg_write, o_cfg_type1;
    wire i_cfg_done, o_wr_retry, o_rd_retry;
    wire [1:0] o_bresp, o_rresp;
    wire [31:0] o_rdata, o_cfg_wdata, i_cfg_rdata;
    wire [7:0] o_cfg_bus;
    wire [4:0] o_cfg_dev;
    wire [2:0] o_cfg_func;
    wire [5:0] o_cfg_word;

    hcer_regs DUT (.*);
    hcer_link_model u_link (.i_clk, .i_rst, .i_cfg_req(o_cfg_req), .i_cfg_bus(o_cfg_bus), .i_cfg_dev(o_cfg_dev),
        .i_cfg_func(o_cfg_func), .i_cfg_word(o_cfg_word), .i_delay(delay), .o_cfg_done(i_cfg_done),
        .o_cfg_rdata(i_cfg_rdata));

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // Capture each launched command at its first cycle
    always @(posedge i_clk) begin
        req_q <= o_cfg_req;
        if (o_cfg_req && !req_q) begin
            launches <= launches + 1;
            cap <= {o_cfg_write, o_cfg_type1, o_cfg_bus, o_cfg_dev, o_cfg_func, o_cfg_word};
            cap_wd <= o_cfg_wdata;
        end
    end

    // ********************************
    // Helpers
    // ********************************
    function automatic [31:0] swap(input [31:0] v);
        swap = {v[7:0], v[15:8], v[23:16], v[31:24]};
    endfunction
    task axi_wr(input [7:0] ad, input [31:0] dt, input [3:0] s, output [1:0] r);
        integer n;
        begin
            n = 0;
            stall = $random(seed) & 3;
            @(posedge i_clk);
            i_awaddr <= ad;
            i_wdata <= dt;
            i_wstrb <= s;
            i_awvalid <= 1'b1;
            i_wvalid <= 1'b1;
            while (!(i_bready && o_bvalid) && n < 400) begin
                @(posedge i_clk);
                n++;
                if (i_awvalid && o_awready) i_awvalid <= 1'b0;
                if (i_wvalid && o_wready) i_wvalid <= 1'b0;
                if (n > stall) i_bready <= 1'b1;
            end
            r = o_bresp;
            i_bready <= 1'b0;
            if (n >= 400) fails++;
        end
    endtask
    task axi_rd(input [7:0] ad, output [31:0] dt, output [1:0] r);
        integer n;
        begin
            n = 0;
            stall = $random(seed) & 3;
            @(posedge i_clk);
            i_araddr <= ad;
            i_arvalid <= 1'b1;
            while (!(i_rready && o_rvalid) && n < 400) begin
                @(posedge i_clk);
                n++;
                if (i_arvalid && o_arready) i_arvalid <= 1'b0;
                if (n > stall) i_rready <= 1'b1;
            end
            dt = o_rdata;
            r = o_rresp;
            i_rready <= 1'b0;
            if (n >= 400) fails++;
        end
    endtask
    task wr_exp(input [7:0] ad, input [31:0] dt, input [3:0] s, input [1:0] er);
        axi_wr(ad, dt, s, rr);
        `CHK(rr, er)
    endtask
    task rd_exp(input [7:0] ad, input [31:0] ed, input [1:0] er);
        axi_rd(ad, rd_d, rr);
        `CHK(rr, er)
        `CHK(rd_d, ed)
    endtask
    task pulse(input integer grp, input [7:0] bits, input [31:0] ad);
        @(posedge i_clk);
        if (grp == 1) i_rd_err <= bits[2:0];
        else i_wr_err <= bits;
        if (grp == 1) i_rd_err_addr <= ad;
        else i_wr_err_addr <= ad;
        @(posedge i_clk);
        i_rd_err <= 3'h0;
        i_wr_err <= 8'h00;
    endtask
    task finish_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge i_clk);
        fails++;
        finish_test();
    end

    // ********************************
    // Tests
    // ********************************
    initial begin
        {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_awaddr, i_araddr, i_wdata} = '0;
        {i_wstrb, i_wr_err, i_rd_err, i_wr_err_addr, i_rd_err_addr, delay} = '0;
        i_rst = 1'b1;
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        for (i = 0; i < 7; i++) rd_exp(8'(i * 4), 32'h0000_0000, `HCER_RESP_OKAY);
        rd_exp(8'h1C, 32'h0000_0000, `HCER_RESP_DECERR);
        rd_exp(8'h02, 32'h0000_0000, `HCER_RESP_DECERR);
        $display("test reset_and_map done");
        wr_exp(`HCER_OFS_CFG_ADDR, 32'hFFFF_FFFF, 4'hF, `HCER_RESP_OKAY);
        rd_exp(`HCER_OFS_CFG_ADDR, 32'h01FF_FF3F, `HCER_RESP_OKAY);
        wr_exp(`HCER_OFS_BUS_NUM, 32'hFFFF_FFFF, 4'hF, `HCER_RESP_OKAY);
        rd_exp(`HCER_OFS_BUS_NUM, 32'hFF00_FF00, `HCER_RESP_OKAY);
        wr_exp(`HCER_OFS_INHIBIT, 32'hFFFF_FFFF, 4'hF, `HCER_RESP_OKAY);
        rd_exp(`HCER_OFS_INHIBIT, 32'hC000_0000, `HCER_RESP_OKAY);
        wr_exp(`HCER_OFS_INHIBIT, 32'h0000_0000, 4'hF, `HCER_RESP_OKAY);
        wr_exp(`HCER_OFS_ERR_DEF, 32'hFFFF_FFFF, 4'hF, `HCER_RESP_OKAY);
        wr_exp(`HCER_OFS_RD_EADDR, 32'hFFFF_FFFF, 4'hF, `HCER_RESP_OKAY);
        wr_exp(`HCER_OFS_WR_EADDR, 32'hFFFF_FFFF, 4'hF, `HCER_RESP_OKAY);
        for (i = 0; i < 3; i++) rd_exp(8'(`HCER_OFS_ERR_DEF + i * 4), 32'h0000_0000, `HCER_RESP_OKAY);
        $display("test field_access done");
        for (i = 0; i < 16; i++) begin
            rnd = $random(seed);
            prim = {1'b0, rnd[6:0]};
            sub = prim + 8'h01 + {2'b00, rnd[12:7]};
            sel = rnd[14:13];
            wr = rnd[15];
            delay <= {1'b0, rnd[18:16]};
            tbus = (sel == 2'd0) ? prim : (sel == 2'd1) ? sub : (sel == 2'd2) ? prim + 8'h01 : sub + 8'h01;
            ok = (sel != 2'd3);
            d = $random(seed);
            wr_exp(`HCER_OFS_BUS_NUM, {sub, 8'h00, prim, 8'h00}, 4'hF, `HCER_RESP_OKAY);
            wr_exp(`HCER_OFS_CFG_ADDR, {7'h00, 1'b1, tbus, rnd[21:19], rnd[26:22], 3'b000, rnd[31:27]}, 4'hF,
                `HCER_RESP_OKAY);
            n0 = launches;
            if (wr) wr_exp(`HCER_OFS_CFG_DATA, d, 4'hF, ok ? `HCER_RESP_OKAY : `HCER_RESP_SLVERR);
            else axi_rd(`HCER_OFS_CFG_DATA, rd_d, rr);
            if (!wr) `CHK(rr, ok ? `HCER_RESP_OKAY : `HCER_RESP_SLVERR)
            if (!wr && ok) `CHK(rd_d, swap({tbus, rnd[21:19], rnd[26:22], 2'b10, 1'b0, rnd[31:27], 8'h5a}))
            `CHK(launches - n0, ok ? 1 : 0)
            if (ok) `CHK(cap, {wr, sel != 2'd0, tbus, rnd[26:22], rnd[21:19], 1'b0, rnd[31:27]})
            if (ok && wr) `CHK(cap_wd, swap(d))
        end
        $display("test config_cycles done");
        n0 = launches;
        wr_exp(`HCER_OFS_CFG_ADDR, {8'h00, prim, 16'h0000}, 4'hF, `HCER_RESP_OKAY);
        wr_exp(`HCER_OFS_CFG_DATA, 32'h1234_5678, 4'hF, `HCER_RESP_OKAY);
        rd_exp(`HCER_OFS_CFG_DATA, 32'h1234_5678, `HCER_RESP_OKAY);
        wr_exp(`HCER_OFS_CFG_ADDR, {8'h01, prim, 16'h0000}, 4'hF, `HCER_RESP_OKAY);
        wr_exp(`HCER_OFS_CFG_DATA, 32'hA5A5_0F0F, 4'h3, `HCER_RESP_SLVERR);
        `CHK(launches - n0, 0)
        $display("test enable_and_width done");
        for (g = 0; g < 2; g++) begin
            lsb = g ? 29 : 21;
            ea = g ? `HCER_OFS_RD_EADDR : `HCER_OFS_WR_EADDR;
            for (k = 0; k < (g ? 3 : 8); k++) begin
                a = $random(seed);
                pulse(g, 8'h01 << k, a);
                rd_exp(`HCER_OFS_ERR_DEF, 32'h0000_0001 << (lsb + k), `HCER_RESP_OKAY);
                rd_exp(ea, a, `HCER_RESP_OKAY);
                wr_exp(`HCER_OFS_ERR_DEF, 32'h0000_0001 << (lsb + k), 4'hF, `HCER_RESP_OKAY);
            end
            wr_exp(`HCER_OFS_INHIBIT, g ? 32'h8000_0000 : 32'h4000_0000, 4'hF, `HCER_RESP_OKAY);
            pulse(g, 8'h01, a);
            pulse(g, 8'h02, ~a);
            rd_exp(ea, a, `HCER_RESP_OKAY);
            `CHK({o_rd_retry, o_wr_retry}, g ? 2'b10 : 2'b01)
            wr_exp(`HCER_OFS_ERR_DEF, 32'hFFE0_0000, 4'hF, `HCER_RESP_OKAY);
            rd_exp(`HCER_OFS_ERR_DEF, 32'h0000_0000, `HCER_RESP_OKAY);
            `CHK({o_rd_retry, o_wr_retry}, 2'b00)
            wr_exp(`HCER_OFS_INHIBIT, 32'h0000_0000, 4'hF, `HCER_RESP_OKAY);
        end
        $display("test error_record done");
        finish_test();
    end
endmodule // hcer_regs_tb

bind hcer_regs hcer_regs_checker u_chk (.*);
